// [cmba_top.v]
// Purpose: chroma demux, blanking decode and vertical flyback sequencer
// Assumes: every video and blanking pin input is asynchronous to clock; register port is synchronous; clk_en freezes all state
// Notes: link clock is sampled, so it must be slower than a quarter of clock
`timescale 1ns/1ps
`include "cmba_consts.vh"
module cmba_top (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire        mux_clk,
  input  wire [3:0]  chroma_in,
  input  wire [7:0]  luma_data_inputs,
  input  wire        blk_a_lo,
  input  wire        blk_a_hi,
  input  wire        blk_b_lo,
  input  wire        blk_b_hi,
  input  wire [4:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output reg  [7:0]  ry_word,
  output reg  [7:0]  by_word,
  output reg         chroma_upd,
  output reg  [7:0]  luma_word,
  output reg  [7:0]  bright_dac,
  output reg  [6:0]  gain_r_out,
  output reg  [6:0]  gain_g_out,
  output reg  [6:0]  gain_b_out,
  output reg  [7:0]  cut_r_out,
  output reg  [7:0]  cut_g_out,
  output reg  [7:0]  cut_b_out,
  output reg  [6:0]  contrast_pct,
  output reg  [2:0]  ublack,
  output reg  [2:0]  black,
  output reg         hblank,
  output reg         color_key,
  output reg         hblank_dly,
  output reg         vblank,
  output reg         fastblank_en,
  output reg         luma_clk_hold,
  output reg         luma_ref_zero,
  output reg         train_valid
);
  localparam ST_IDLE = 6'b000001;
  localparam ST_RECV = 6'b000010;
  localparam ST_HOLD = 6'b000100;
  localparam ST_VWT  = 6'b001000;
  localparam ST_MEAS = 6'b010000;
  localparam ST_REFZ = 6'b100000;

  // returns {high level, middle level} of a three-level line
  function [1:0] tri_dec;
    input lo;
    input hi;
    begin
      tri_dec = {hi, lo & ~hi};
    end
  endfunction

  function [6:0] con_pct;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   con_pct = `CMBA_CON_10;
        2'b01:   con_pct = `CMBA_CON_30;
        2'b10:   con_pct = `CMBA_CON_50;
        default: con_pct = `CMBA_CON_70;
      endcase
    end
  endfunction

  // two-stage synchronisers; stage one is read only by stage two
  reg  [16:0] sync1;
  reg  [16:0] sync2;
  reg         mclk_d;
  reg         c0_d;
  reg         hb_d;
  wire [16:0] pins = {mux_clk, chroma_in, luma_data_inputs,
                      blk_a_lo, blk_a_hi, blk_b_lo, blk_b_hi};
  wire        s_mclk = sync2[16];
  wire [3:0]  s_chr  = sync2[15:12];
  wire [7:0]  s_luma = sync2[11:4];
  wire [1:0]  dec_a  = tri_dec(sync2[3], sync2[2]); // [R14]
  wire [1:0]  dec_b  = tri_dec(sync2[1], sync2[0]); // [R14]
  wire        mclk_rise = s_mclk & ~mclk_d;
  wire        c0_rise   = s_chr[0] & ~c0_d;
  wire        hb_now    = dec_a[0] | dec_b[0];
  wire        line_tick = dec_a[0] & ~hb_d;
  wire        vb_now    = dec_b[1];

  always @(posedge clock) begin
    if (sys_rst) begin
      sync1  <= 17'h00000;
      sync2  <= 17'h00000;
      mclk_d <= 1'b0;
      c0_d   <= 1'b0;
      hb_d   <= 1'b0;
    end else if (clk_en) begin
      sync1  <= pins;
      sync2  <= sync1;
      mclk_d <= s_mclk;
      c0_d   <= s_chr[0];
      hb_d   <= dec_a[0];
    end
  end

  // software settings and status port
  reg  [7:0] bright;
  reg  [6:0] gain_r;
  reg  [6:0] gain_g;
  reg  [6:0] gain_b;
  reg  [7:0] cut_r;
  reg  [7:0] cut_g;
  reg  [7:0] cut_b;
  reg  [7:0] train_byte [0:8];
  reg        sync_mode;
  reg  [5:0] state;
  wire [4:0] tidx = reg_addr - `CMBA_ADDR_TRAIN0;

  always @(posedge clock) begin
    if (sys_rst) begin
      bright    <= `CMBA_RST_BRIGHT;
      gain_r    <= `CMBA_RST_GAIN;
      gain_g    <= `CMBA_RST_GAIN;
      gain_b    <= `CMBA_RST_GAIN;
      cut_r     <= `CMBA_RST_CUT;
      cut_g     <= `CMBA_RST_CUT;
      cut_b     <= `CMBA_RST_CUT;
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_wr) begin
        case (reg_addr)
          `CMBA_ADDR_BRIGHT: bright <= reg_wdata;      // [R5]
          `CMBA_ADDR_GAIN_R: gain_r <= reg_wdata[6:0]; // [R6]
          `CMBA_ADDR_GAIN_G: gain_g <= reg_wdata[6:0]; // [R6]
          `CMBA_ADDR_GAIN_B: gain_b <= reg_wdata[6:0]; // [R6]
          `CMBA_ADDR_CUT_R:  cut_r  <= reg_wdata;      // [R7]
          `CMBA_ADDR_CUT_G:  cut_g  <= reg_wdata;      // [R7]
          `CMBA_ADDR_CUT_B:  cut_b  <= reg_wdata;      // [R7]
          default: ;
        endcase
      end
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `CMBA_ADDR_BRIGHT: reg_rdata <= bright;
          `CMBA_ADDR_GAIN_R: reg_rdata <= {1'b0, gain_r};
          `CMBA_ADDR_GAIN_G: reg_rdata <= {1'b0, gain_g};
          `CMBA_ADDR_GAIN_B: reg_rdata <= {1'b0, gain_b};
          `CMBA_ADDR_CUT_R:  reg_rdata <= cut_r;
          `CMBA_ADDR_CUT_G:  reg_rdata <= cut_g;
          `CMBA_ADDR_CUT_B:  reg_rdata <= cut_b;
          `CMBA_ADDR_STATUS: reg_rdata <= {train_valid, sync_mode, vblank, hblank,
                                           1'b0, ublack};
          default: begin
            if (reg_addr >= `CMBA_ADDR_TRAIN0 && reg_addr <= `CMBA_ADDR_TRAIN8)
              reg_rdata <= train_byte[tidx[3:0]];
          end
        endcase
      end
    end
  end

  // chroma nibble demux; phase counts nibbles of the 16-bit group
  reg  [1:0] phase;
  reg  [3:0] nib0;
  reg  [3:0] nib1;
  reg  [3:0] nib2;

  always @(posedge clock) begin
    if (sys_rst) begin
      phase      <= 2'd0;
      nib0       <= 4'h0;
      nib1       <= 4'h0;
      nib2       <= 4'h0;
      ry_word    <= 8'h00;
      by_word    <= 8'h00;
      chroma_upd <= 1'b0;
      sync_mode  <= 1'b0;
      luma_word  <= 8'h00;
    end else if (clk_en) begin
      chroma_upd <= 1'b0;
      // sender keeps zero luma inside hblank, so the code is trusted there
      if (hb_now && s_luma == 8'h00)
        sync_mode <= 1'b1; // [R3] [R4]
      else if (!hb_now)
        sync_mode <= 1'b0;
      if (mclk_rise)
        luma_word <= s_luma;
      if (sync_mode || vb_now) begin
        if (c0_rise)
          phase <= 2'd0;
      end else if (mclk_rise) begin
        phase <= phase + 2'd1; // [R1]
        case (phase)
          2'd0: nib0 <= s_chr;
          2'd1: nib1 <= s_chr;
          2'd2: nib2 <= s_chr;
          default: begin
            ry_word    <= {nib0, nib1}; // [R1] [R2]
            by_word    <= {nib2, s_chr};
            chroma_upd <= 1'b1;         // [R2]
          end
        endcase
      end
    end
  end

  // flyback sequencer counted in lines
  reg  [5:0] next_state;
  reg  [3:0] lines;
  reg        vb_d;
  wire       vb_rise = vb_now & ~vb_d;
  wire       vb_fall = ~vb_now & vb_d;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: if (vb_rise) next_state = ST_RECV; // [R13] [R15]
      ST_RECV: if (!vb_now) next_state = ST_MEAS;
               else if (line_tick && lines == `CMBA_RECV_LINES - 4'd1)
                 next_state = ST_HOLD; // [R19]
      ST_HOLD: if (!vb_now) next_state = ST_MEAS;
               else if (line_tick && lines == `CMBA_HOLD_LINES - 4'd1)
                 next_state = ST_VWT;
      ST_VWT:  if (vb_fall) next_state = ST_MEAS; // [R15]
      ST_MEAS: if (line_tick && lines == `CMBA_MEAS_LINES - 4'd1)
                 next_state = ST_REFZ;
      ST_REFZ: if (line_tick && lines == `CMBA_REFZ_LINES - 4'd1)
                 next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      lines <= 4'd0;
      vb_d  <= 1'b0;
    end else if (clk_en) begin
      vb_d  <= vb_now;
      state <= next_state;
      if (next_state != state)
        lines <= 4'd0;
      else if (line_tick)
        lines <= lines + 4'd1;
    end
  end

  // control train: clock pulses on the shared line, data on chroma line 1
  reg  [71:0] shift;
  reg  [71:0] held;
  reg  [6:0]  bits;
  integer     k;

  always @(posedge clock) begin
    if (sys_rst) begin
      shift       <= 72'h0;
      held        <= {72{1'b1}};
      bits        <= 7'd0;
      train_valid <= 1'b0;
      for (k = 0; k < 9; k = k + 1)
        train_byte[k] <= 8'h00;
    end else if (clk_en) begin
      if (state == ST_IDLE && vb_rise)
        bits <= 7'd0; // [R12]
      else if (state == ST_RECV && c0_rise && bits != `CMBA_TRAIN_BITS) begin
        shift <= {shift[70:0], s_chr[1]}; // [R24] [R25]
        bits  <= bits + 7'd1;
        if (bits == `CMBA_TRAIN_BITS - 7'd1) begin
          held        <= {shift[70:0], s_chr[1]}; // [R25]
          train_valid <= 1'b1;
          // byte 8 takes the bit arriving now, so the loop stops short of it
          for (k = 0; k < 8; k = k + 1)
            train_byte[k] <= shift[70 - 8*k -: 8];
          train_byte[8] <= {shift[6:0], s_chr[1]};
        end
      end
    end
  end

  // outputs; a short train keeps the previous fields
  wire [2:0] code = {held[`CMBA_BIT_CODE_R], held[`CMBA_BIT_CODE_G],
                     held[`CMBA_BIT_CODE_B]};
  wire       meas = (state == ST_MEAS);
  wire       dblk = vb_now | meas;

  always @(posedge clock) begin
    if (sys_rst) begin
      ublack        <= 3'b111;
      black         <= 3'b000;
      hblank        <= 1'b0;
      color_key     <= 1'b0;
      hblank_dly    <= 1'b0;
      vblank        <= 1'b0;
      fastblank_en  <= 1'b0;
      luma_clk_hold <= 1'b0;
      luma_ref_zero <= 1'b0;
      bright_dac    <= 8'h00;
      gain_r_out    <= `CMBA_RST_GAIN;
      gain_g_out    <= `CMBA_RST_GAIN;
      gain_b_out    <= `CMBA_RST_GAIN;
      cut_r_out     <= `CMBA_RST_CUT;
      cut_g_out     <= `CMBA_RST_CUT;
      cut_b_out     <= `CMBA_RST_CUT;
      contrast_pct  <= `CMBA_CON_10;
    end else if (clk_en) begin
      hblank     <= dec_a[0];
      color_key  <= dec_a[1];
      hblank_dly <= dec_b[0];
      vblank     <= dec_b[1];
      if (meas) begin
        ublack <= code;  // [R10] [R11] [R23]
        black  <= ~code; // [R10]
      end else if (hb_now || vb_now || state == ST_RECV) begin
        ublack <= 3'b111; // [R9] [R13] [R16]
        black  <= 3'b000;
      end else begin
        ublack <= 3'b000;
        black  <= 3'b000;
      end
      fastblank_en  <= ~dblk;                       // [R16]
      bright_dac    <= dblk ? 8'h00 : bright;       // [R5] [R16]
      luma_clk_hold <= (state == ST_HOLD);          // [R17] [R19]
      luma_ref_zero <= (state == ST_REFZ);          // [R18]
      gain_r_out    <= gain_r;                      // [R6]
      gain_g_out    <= gain_g;
      gain_b_out    <= gain_b;
      cut_r_out     <= cut_r;                       // [R7]
      cut_g_out     <= cut_g;
      cut_b_out     <= cut_b;
      contrast_pct  <= con_pct({held[`CMBA_BIT_CON_L], held[`CMBA_BIT_CON_M]}); // [R8]
    end
  end
endmodule

// [cmba_consts.vh]
// Purpose: constants for the chroma mux and blanking alignment block
// Assumes: double-scan clock domain, all video and blanking pins synchronised in the block; register port used directly
// Notes: bit positions of the control train count from the last bit received
// Functional notes
// [R1] four 4-bit nibbles form one 16-bit group
// [R2] update both chroma words once per group
// [R3] zero luma in hblank switches line to sync
// [R4] sender keeps zero luma inside hblank only
// [R5] 8-bit brightness offset, 255 steps
// [R6] 7-bit white-balance gain per channel
// [R7] 8-bit cutoff bias per channel
// [R8] contrast bits select 10/30/50/70 percent
// [R9] horizontal flyback forces all outputs ultra black; code lets the ST_MEAS code pattern win over it on measuring lines
// [R10] measuring: cathode under test black, others ultra
// [R11] leakage phase holds all three ultra black
// [R12] 72-bit train per vblank carries cathode code
// [R13] train starts at vblank, outputs ultra black
// [R14] two thresholds split each blanking line
// [R15] sender gives 13-line vblank pulse
// [R16] blanking pulse zeroes converters, disables fast blank
// [R17] clock hold-off gives white measuring level
// [R18] reference-zero window gives zero luma
// [R19] 4-line receive window, end starts hold-off
// [R20] sender sends 72 train clocks on shared line
// [R21] sender resumes data after its 6-line window
// [R22] sender drives white level on lines 19-20
// [R23] code bit 1 forces channel ultra black
// [R24] nine bytes, msb first, one bit per pulse
// [R25] shift in bits, update fields after 72
`ifndef CMBA_CONSTS_VH
`define CMBA_CONSTS_VH
`define CMBA_TRAIN_BITS    7'd72
`define CMBA_TRAIN_CNT_W   7
`define CMBA_RECV_LINES    4'd4
`define CMBA_HOLD_LINES    4'd2
`define CMBA_MEAS_LINES    4'd2
`define CMBA_REFZ_LINES    4'd1
`define CMBA_BIT_CODE_R    68
`define CMBA_BIT_CODE_G    67
`define CMBA_BIT_CODE_B    66
`define CMBA_BIT_CON_L     1
`define CMBA_BIT_CON_M     0
`define CMBA_ADDR_BRIGHT   5'h00
`define CMBA_ADDR_GAIN_R   5'h01
`define CMBA_ADDR_GAIN_G   5'h02
`define CMBA_ADDR_GAIN_B   5'h03
`define CMBA_ADDR_CUT_R    5'h04
`define CMBA_ADDR_CUT_G    5'h05
`define CMBA_ADDR_CUT_B    5'h06
`define CMBA_ADDR_STATUS   5'h07
`define CMBA_ADDR_TRAIN0   5'h08
`define CMBA_ADDR_TRAIN8   5'h10
`define CMBA_RST_BRIGHT    8'h80
`define CMBA_RST_GAIN      7'h40
`define CMBA_RST_CUT       8'h80
`define CMBA_CON_10        7'h0a
`define CMBA_CON_30        7'h1e
`define CMBA_CON_50        7'h32
`define CMBA_CON_70        7'h46
`endif

// [cmba_properties.sv]
// Purpose: concurrent checks on the ports of cmba_top
// Assumes: clk_en held high by the bench; one clock domain
// Notes: decode checks wait three cycles after reset for the synchronisers
`timescale 1ns/1ps
`include "cmba_consts.vh"
module cmba_props (
  input logic       clock,
  input logic       sys_rst,
  input logic       blk_a_lo,
  input logic       blk_a_hi,
  input logic       blk_b_hi,
  input logic       reg_wr,
  input logic [4:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] ry_word,
  input logic       chroma_upd,
  input logic [7:0] bright_dac,
  input logic [6:0] gain_r_out,
  input logic [6:0] contrast_pct,
  input logic [2:0] ublack,
  input logic [2:0] black,
  input logic       hblank,
  input logic       vblank,
  input logic       fastblank_en,
  input logic       luma_clk_hold,
  input logic       luma_ref_zero
);
  logic [1:0] age;
  // synchroniser flops hold their reset zeros, not the pins, for three cycles
  always @(posedge clock) begin
    if (sys_rst) age <= 2'd0;
    else if (age != 2'd3) age <= age + 2'd1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence vb_held;
    $past(vblank) && vblank;
  endsequence
  sequence wr_gain_r;
    reg_wr && reg_addr == `CMBA_ADDR_GAIN_R ##2 1'b1;
  endsequence
  hblank_decode_a: assert property (age == 2'd3 |-> hblank == $past(blk_a_lo && !blk_a_hi, 3))
    else $error("hblank decode wrong");
  vblank_decode_a: assert property (age == 2'd3 |-> vblank == $past(blk_b_hi, 3))
    else $error("vblank decode wrong");
  hflyback_ultra_a: assert property (hblank && $past(hblank) && black == 3'b000 |-> ublack == 3'b111)
    else $error("hblank without ultra black");
  measure_split_a: assert property (black != 3'b000 |-> (black ^ ublack) == 3'b111)
    else $error("measure outputs not complementary");
  vblank_blank_a: assert property (vb_held |-> ublack == 3'b111 && bright_dac == 8'h00 && !fastblank_en)
    else $error("vblank outputs not blanked");
  chroma_hold_a: assert property (!$stable(ry_word) && ublack == 3'b000 && $past(ublack) == 3'b000 |-> chroma_upd)
    else $error("chroma word moved without update");
  upd_pulse_a: assert property (chroma_upd |=> !chroma_upd)
    else $error("chroma update longer than one cycle");
  gain_write_a: assert property (wr_gain_r |-> gain_r_out == $past(reg_wdata[6:0], 2))
    else $error("gain write not applied");
  contrast_code_a: assert property (contrast_pct inside {`CMBA_CON_10, `CMBA_CON_30, `CMBA_CON_50, `CMBA_CON_70})
    else $error("contrast level illegal");
  window_excl_a: assert property (luma_clk_hold |-> !luma_ref_zero)
    else $error("hold-off and ref zero overlap");
  hold_start_a: assert property ($rose(luma_clk_hold) |-> vblank)
    else $error("hold-off began outside vblank");
endmodule
bind cmba_top cmba_props i_cmba_props (.*);

// [cmba_src.sv]
// Purpose: upstream scan and deflection source for cmba_top
// Assumes: pins move only inside tasks called by the bench
// Notes: link clock stands still between transfers
`timescale 1ns/1ps
module cmba_src (
  output logic       mux_clk,
  output logic [3:0] chroma_in,
  output logic [7:0] luma_data_inputs,
  output logic       blk_a_lo,
  output logic       blk_a_hi,
  output logic       blk_b_lo,
  output logic       blk_b_hi
);
  initial begin
    mux_clk = 1'b0;
    chroma_in = 4'h0;
    luma_data_inputs = 8'h10;
    blk_a_lo = 1'b0;
    blk_a_hi = 1'b0;
    blk_b_lo = 1'b0;
    blk_b_hi = 1'b0;
  end
  task automatic nib(logic [3:0] n);
    chroma_in = n;
    #62.5 mux_clk = 1'b1;
    #62.5 mux_clk = 1'b0;
  endtask
  task automatic group(logic [7:0] ry, logic [7:0] by);
    nib(ry[7:4]);
    nib(ry[3:0]);
    nib(by[7:4]);
    nib(by[3:0]);
    // a released line must not keep showing the last nibble
    chroma_in = ~by[3:0];
  endtask
  task automatic vbl(logic on);
    blk_b_lo = on;
    blk_b_hi = on;
  endtask
  task automatic line();
    blk_a_lo = 1'b1;
    if (!blk_b_hi) blk_b_lo = 1'b1;
    #1000;
    blk_a_lo = 1'b0;
    if (!blk_b_hi) blk_b_lo = 1'b0;
    #2000;
  endtask
  task automatic sync_pulse();
    blk_a_lo = 1'b1;
    #200;
    luma_data_inputs = 8'h00;
    nib(4'h0);
    chroma_in[0] = 1'b1;
    #62.5 chroma_in[0] = 1'b0;
    luma_data_inputs = 8'h10;
    #200 blk_a_lo = 1'b0;
    #200;
  endtask
  task automatic train(logic [71:0] b);
    #100;
    for (int i = 71; i >= 0; i--) begin
      chroma_in[1] = b[i];
      chroma_in[0] = 1'b0;
      #62.5 chroma_in[0] = 1'b1;
      #62.5;
    end
    // line stays parked until the bench resumes groups after the frame
    chroma_in = {2'b00, ~b[0], 1'b0};
  endtask
  // measuring level chosen here; any non-zero code keeps clear of the sync code
  localparam logic [7:0] WHITE_LVL = 8'he0;
  task automatic pulses(logic [3:0] v);
    {blk_a_lo, blk_a_hi, blk_b_lo, blk_b_hi} = v;
  endtask
  task automatic white_lines();
    luma_data_inputs = WHITE_LVL;
    line();
    line();
    luma_data_inputs = 8'h10;
  endtask
endmodule

// [tb.sv]
// Purpose: self-checking bench for cmba_top
// Assumes: clk_en held high; cmba_src drives every video and blanking pin
// Notes: one short frame per code of the four-field cycle
`timescale 1ns/1ps
`include "cmba_consts.vh"
module tb;
  logic        clock, sys_rst, clk_en, reg_wr, reg_rd;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata;
  wire         mux_clk, chroma_upd, blk_a_lo, blk_a_hi, blk_b_lo, blk_b_hi;
  wire         hblank, color_key, hblank_dly, vblank, fastblank_en;
  wire         luma_clk_hold, luma_ref_zero, train_valid;
  wire [3:0]   chroma_in;
  wire [2:0]   ublack, black;
  wire [6:0]   gain_r_out, gain_g_out, gain_b_out, contrast_pct;
  wire [7:0]   reg_rdata, ry_word, by_word, luma_word, bright_dac, luma_data_inputs;
  wire [7:0]   cut_r_out, cut_g_out, cut_b_out;
  int          miscompares = 0, compares = 0, cyc = 0;
  logic [71:0] tr;
  logic [2:0]  code [4] = '{3'b111, 3'b011, 3'b101, 3'b110};
  logic [7:0]  rstv [7] = '{8'h80, 8'h40, 8'h40, 8'h40, 8'h80, 8'h80, 8'h80};
  cmba_top i_cmba_top (.*);
  cmba_src i_cmba_src (.*);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // expected run is about 30000 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      complete_run;
    end
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [4:0] a, logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic frame(int f);
    tr = {24'ha53c00 + 24'(f), 48'h0123456789ab};
    tr[68:66] = code[f];
    tr[1:0] = 2'(f);
    i_cmba_src.vbl(1'b1);
    i_cmba_src.train(tr);
    repeat (5) @(posedge clock);
    #1;
    chk("ublack", 8'h07, ublack);
    chk("bright_dac", 8'h00, bright_dac);
    chk("fastblank_en", 8'h00, fastblank_en);
    chk("train_valid", 8'h01, train_valid);
    for (int i = 1; i <= 13; i++) begin
      i_cmba_src.line();
      if (i == 3 || i == 5) chk("luma_clk_hold", 8'(i == 5), luma_clk_hold);
    end
    i_cmba_src.vbl(1'b0);
    repeat (10) @(posedge clock);
    #1;
    chk("ublack", {5'h0, code[f]}, ublack);
    chk("black", {5'h0, ~code[f]}, black);
    chk("contrast_pct", 8'(10 + 20 * f), contrast_pct);
    i_cmba_src.white_lines();
    chk("luma_ref_zero", 8'h01, luma_ref_zero);
    i_cmba_src.line();
    for (int k = 0; k < 9; k++) rd(5'(`CMBA_ADDR_TRAIN0 + k), tr[71 - 8 * k -: 8]);
    // chroma and luma data resume once the sender's window is over
    i_cmba_src.group(8'h96 ^ 8'(f), 8'h5a);
    repeat (6) @(posedge clock);
    #1;
    chk("ry_word", 8'h96 ^ 8'(f), ry_word);
    chk("luma_word", 8'h10, luma_word);
  endtask
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    for (int a = 0; a < 7; a++) rd(5'(a), rstv[a]);
    rd(5'h1f, 8'h00);
    // held fields reset to ones, so the limiter starts at its top level
    chk("contrast_pct", 8'h46, contrast_pct);
    chk("train_valid", 8'h00, train_valid);
    chk("gain_g_out", 8'h40, gain_g_out);
    chk("gain_b_out", 8'h40, gain_b_out);
    chk("cut_r_out", 8'h80, cut_r_out);
    chk("cut_g_out", 8'h80, cut_g_out);
    wr(`CMBA_ADDR_BRIGHT, 8'hff);
    wr(`CMBA_ADDR_GAIN_R, 8'h7f);
    wr(`CMBA_ADDR_CUT_B, 8'h01);
    rd(`CMBA_ADDR_GAIN_R, 8'h7f);
    chk("bright_dac", 8'hff, bright_dac);
    chk("cut_b_out", 8'h01, cut_b_out);
    i_cmba_src.group(8'ha5, 8'h3c);
    repeat (6) @(posedge clock);
    #1;
    chk("ry_word", 8'ha5, ry_word);
    chk("by_word", 8'h3c, by_word);
    // half a group left pending; only a sync or vblank realignment can recover it
    i_cmba_src.nib(4'h1);
    i_cmba_src.nib(4'h2);
    i_cmba_src.sync_pulse();
    i_cmba_src.group(8'h69, 8'hc3);
    repeat (6) @(posedge clock);
    #1;
    chk("ry_word", 8'h69, ry_word);
    chk("by_word", 8'hc3, by_word);
    // line A at its top level is the colour key, line B at mid level the late blanking
    i_cmba_src.pulses(4'b1110);
    repeat (6) @(posedge clock);
    #1;
    chk("color_key", 8'h01, color_key);
    chk("hblank", 8'h00, hblank);
    chk("hblank_dly", 8'h01, hblank_dly);
    chk("ublack", 8'h07, ublack);
    i_cmba_src.pulses(4'b0000);
    for (int f = 0; f < 4; f++) frame(f);
    complete_run;
  end
endmodule
